// ===== rtl/flash_muxed_bus_interface.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// [R1] Reset pin low: ignore inputs, outputs high-Z
// [R2] Reset aborts program, location left undefined
// [R3] Host waits recovery time after reset release
// [R4] Chip deselected: standby, outputs high-Z
// [R5] Standby lets running program finish
// [R6] Output enable high: high-Z, wait deasserted
// [R7] Sync bit one: asynchronous reads
// [R8] Host holds controls steady during async reads
// [R9] Async data after slowest access delay
// [R10] Sync bit zero starts clocked burst read
// [R11] First burst word after latency count
// [R12] Array burst: next address each edge
// [R13] Non-array burst repeats same word
// [R14] Slow grade latches address first edge
// [R15] Fast grade latches last low edge
// [R16] Start address picks first word out
// [R17] Wrap bit: wrap in group or continue
// [R18] No stall when aligned or not crossing
// [R19] Misaligned crossing stalls latency minus one; the code stalls only when latency is above 2
// [R20] Writes asynchronous, data on first rising edge
// [R21] Write address on first valid/select rise
// [R22] Host toggles select between read and write
// [R23] Wait polarity configurable, marks data invalid
// [R24] Low address on data lines, high dedicated
// [R25] Latency and length from read config register
module flash_muxed_bus_interface #(
    parameter bit FAST_GRADE = 1'b0
) (
    input  wire logic                        ref_clk,
    input  wire logic                        resetn,
    input  wire logic                        burst_clk,
    input  wire flash_bus_pkg::bus_ctrl_type ctrl,
    input  wire logic [9:0]                  addr_hi,
    input  wire logic [15:0]                 dq_in,
    output var  logic [15:0]                 dq_out,
    output var  logic                        dq_oe,
    output var  logic                        wait_out,
    output var  logic                        wait_oe,
    input  wire logic [15:0]                 read_config_reg,
    input  wire logic                        nonarray_mode,
    input  wire logic [15:0]                 nonarray_word,
    output var  logic                        program_busy
);
    import flash_bus_pkg::*;

    typedef enum logic [2:0] {B_IDLE, B_LAT, B_DATA, B_STALL, B_DONE} burst_state_type;
    typedef enum logic {P_IDLE, P_BUSY} prog_state_type;

    function automatic logic [3:0] lat_of(input logic [15:0] cfg);
        logic [3:0] l;
        l = cfg[CFG_LAT_LSB +: 4];
        return (l < LAT_MIN) ? LAT_MIN : l;
    endfunction

    function automatic logic [4:0] len_of(input logic [15:0] cfg);
        unique case (cfg[CFG_BL_LSB +: 3])
            BL_8:    return 5'h08;
            BL_16:   return 5'h10;
            BL_CONT: return 5'h00;
            default: return 5'h04;
        endcase
    endfunction

    function automatic logic [25:0] next_addr(input logic [25:0] a, input logic [4:0] len,
                                              input logic wrap);
        logic [25:0] inc;
        logic [25:0] msk;
        inc = a + 26'h1;
        msk = 26'(len) - 26'h1;
        if (wrap && len != 5'h00) begin
            return (a & ~msk) | (inc & msk);
        end
        return inc;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Burst clock domain

    logic [15:0]     bcfg1_ff;
    logic [15:0]     bcfg2_ff;
    logic [16:0]     bna1_ff;
    logic [16:0]     bna2_ff;
    burst_state_type bstate_ff;
    burst_state_type nxt_bstate;
    logic [25:0]     baddr_ff;
    logic [25:0]     nxt_baddr;
    logic [25:0]     bstart_ff;
    logic [3:0]      bcnt_ff;
    logic [4:0]      bwords_ff;
    logic            bstalled_ff;
    burst_out_type   bout_ff;
    logic            btog_ff;
    logic [15:0]     bmem_q;
    logic            bstart;
    logic            bdesel;
    logic            bemit;
    logic            bcross;
    logic            blast;
    logic [25:0]     badv;

    // Config and mode are quasi-static; two flops bring them over
    always_ff @(posedge burst_clk or negedge resetn) begin
        if (!resetn) begin
            bcfg1_ff <= CFG_RESET;
            bcfg2_ff <= CFG_RESET;
            bna1_ff  <= 17'h00000;
            bna2_ff  <= 17'h00000;
        end else begin
            bcfg1_ff <= read_config_reg;
            bcfg2_ff <= bcfg1_ff;
            bna1_ff  <= {nonarray_mode, nonarray_word};
            bna2_ff  <= bna1_ff;
        end
    end

    assign bdesel = !ctrl.rst_n || ctrl.ce_n; // R1 R4
    assign bstart = ctrl.rst_n && !ctrl.ce_n && !ctrl.oe_n && !ctrl.addr_valid_n
                    && ctrl.we_n && !bcfg2_ff[CFG_SYNC_BIT]; // R10
    assign bemit  = bstate_ff == B_DATA;
    assign badv   = bna2_ff[16] ? baddr_ff
                  : next_addr(baddr_ff, len_of(bcfg2_ff), bcfg2_ff[CFG_WRAP_BIT]); // R12 R13 R17
    assign blast  = len_of(bcfg2_ff) != 5'h00 && bwords_ff + 5'h01 == len_of(bcfg2_ff); // R12
    assign bcross = !bna2_ff[16] && !bstalled_ff
                    && badv[25:WORDLINE_BITS] != baddr_ff[25:WORDLINE_BITS]
                    && bstart_ff[SENSE_BITS-1:0] != '0; // R18 R19

    always_comb begin
        nxt_bstate = bstate_ff;
        nxt_baddr  = baddr_ff;
        if (bdesel) begin
            nxt_bstate = B_IDLE;
        end else begin
            unique case (bstate_ff)
                B_IDLE: begin
                    if (bstart) begin
                        nxt_bstate = B_LAT;
                        nxt_baddr  = {addr_hi, dq_in}; // R14 R16 R24
                    end
                end
                B_LAT: begin
                    if (FAST_GRADE && !ctrl.addr_valid_n) begin
                        nxt_baddr = {addr_hi, dq_in}; // R15
                    end
                    if (bcnt_ff == 4'h1) begin
                        nxt_bstate = B_DATA; // R11
                    end
                end
                B_DATA: begin
                    nxt_baddr = badv;
                    if (blast) begin
                        nxt_bstate = B_DONE;
                    end else if (bcross && lat_of(bcfg2_ff) > 4'h2) begin
                        nxt_bstate = B_STALL; // R19
                    end
                end
                B_STALL: begin
                    if (bcnt_ff == 4'h1) begin
                        nxt_bstate = B_DATA;
                    end
                end
                B_DONE: begin
                    nxt_bstate = B_DONE;
                end
            endcase
        end
    end

    always_ff @(posedge burst_clk or negedge resetn) begin
        if (!resetn) begin
            bstate_ff <= B_IDLE;
            baddr_ff  <= '0;
            bstart_ff <= '0;
        end else begin
            bstate_ff <= nxt_bstate;
            baddr_ff  <= nxt_baddr;
            if (nxt_bstate == B_LAT) begin
                bstart_ff <= nxt_baddr; // R16
            end
        end
    end

    // Latency and stall counters
    always_ff @(posedge burst_clk or negedge resetn) begin
        if (!resetn) begin
            bcnt_ff     <= 4'h0;
            bwords_ff   <= 5'h00;
            bstalled_ff <= 1'b0;
        end else if (bstate_ff == B_IDLE) begin
            bcnt_ff     <= lat_of(bcfg2_ff); // R25
            bwords_ff   <= 5'h00;
            bstalled_ff <= 1'b0;
        end else if (bemit) begin
            bwords_ff <= bwords_ff + 5'h01;
            if (nxt_bstate == B_STALL) begin
                bcnt_ff     <= lat_of(bcfg2_ff) - 4'h1; // R19
                bstalled_ff <= 1'b1;
            end
        end else if (bcnt_ff != 4'h0) begin
            bcnt_ff <= bcnt_ff - 4'h1;
        end
    end

    // Output word, wait level and word toggle toward the output stage
    always_ff @(posedge burst_clk or negedge resetn) begin
        if (!resetn) begin
            bout_ff <= '0;
            btog_ff <= 1'b0;
        end else begin
            bout_ff.active  <= nxt_bstate != B_IDLE;
            bout_ff.wait_on <= nxt_bstate == B_LAT || nxt_bstate == B_STALL
                               || bstate_ff == B_LAT; // R11 R19 R23
            if (bemit) begin
                bout_ff.word <= bna2_ff[16] ? bna2_ff[15:0] : bmem_q; // R12 R13
                btog_ff      <= !btog_ff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reference clock domain: pin synchronisers

    bus_ctrl_type  c1_ff;
    bus_ctrl_type  c2_ff;
    bus_ctrl_type  c3_ff;
    logic [25:0]   ad1_ff;
    logic [25:0]   ad2_ff;
    burst_out_type bo1_ff;
    burst_out_type bo2_ff;
    logic [2:0]    tog_ff;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            c1_ff  <= '1;
            c2_ff  <= '1;
            c3_ff  <= '1;
            ad1_ff <= '0;
            ad2_ff <= '0;
            bo1_ff <= '0;
            bo2_ff <= '0;
            tog_ff <= 3'h0;
        end else begin
            c1_ff  <= ctrl;
            c2_ff  <= c1_ff;
            c3_ff  <= c2_ff;
            ad1_ff <= {addr_hi, dq_in};
            ad2_ff <= ad1_ff;
            bo1_ff <= bout_ff;
            bo2_ff <= bo1_ff;
            tog_ff <= {tog_ff[1:0], btog_ff};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address latch, async access timer, write and program

    logic           live;
    logic           rd_req;
    logic           wr_act;
    logic           wr_prev_ff;
    logic [25:0]    aaddr_ff;
    logic [1:0]     acc_ff;
    logic [15:0]    wdata_ff;
    logic [25:0]    paddr_ff;
    logic [15:0]    pdata_ff;
    logic [5:0]     pcnt_ff;
    prog_state_type pstate_ff;
    logic           mem_we;
    logic [15:0]    mem_wd;
    logic [15:0]    amem_q;
    logic           wr_end;
    logic           sync_mode;

    assign live      = c2_ff.rst_n && !c2_ff.ce_n; // R1 R4
    assign sync_mode = !read_config_reg[CFG_SYNC_BIT];
    assign rd_req    = live && !c2_ff.oe_n && c2_ff.we_n && !sync_mode; // R7
    assign wr_act    = live && !c2_ff.we_n && c2_ff.oe_n; // R20
    assign wr_end    = wr_prev_ff && !wr_act && c2_ff.rst_n;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            aaddr_ff   <= '0;
            acc_ff     <= 2'(ACCESS_CYC);
            wdata_ff   <= 16'h0000;
            wr_prev_ff <= 1'b0;
        end else begin
            wr_prev_ff <= wr_act;
            if (live && !c2_ff.addr_valid_n && c2_ff.oe_n) begin
                aaddr_ff <= ad2_ff; // R21 R24
            end
            if (wr_act) begin
                wdata_ff <= ad2_ff[15:0]; // R20
            end
            if (!rd_req || c2_ff.addr_valid_n != c3_ff.addr_valid_n
                || !c3_ff.oe_n != !c2_ff.oe_n || c3_ff.ce_n) begin
                acc_ff <= 2'(ACCESS_CYC); // R9
            end else if (acc_ff != 2'h0) begin
                acc_ff <= acc_ff - 2'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pstate_ff <= P_IDLE;
            pcnt_ff   <= 6'h00;
            paddr_ff  <= '0;
            pdata_ff  <= 16'h0000;
        end else begin
            unique case (pstate_ff)
                P_IDLE: begin
                    if (wr_end) begin
                        pstate_ff <= P_BUSY;
                        pcnt_ff   <= 6'(PROG_CYC);
                        paddr_ff  <= aaddr_ff;
                        pdata_ff  <= wdata_ff;
                    end
                end
                P_BUSY: begin
                    if (!c2_ff.rst_n || pcnt_ff == 6'h01) begin
                        pstate_ff <= P_IDLE; // R2 R5
                    end else begin
                        pcnt_ff <= pcnt_ff - 6'h01;
                    end
                end
            endcase
        end
    end

    assign mem_we = pstate_ff == P_BUSY && (!c2_ff.rst_n || pcnt_ff == 6'h01);
    assign mem_wd = c2_ff.rst_n ? pdata_ff : (pdata_ff & ABORT_MASK); // R2

    flash_word_mem u_mem (
        .a_clk   (ref_clk),
        .a_we    (mem_we),
        .a_addr  (mem_we ? paddr_ff[MEM_AW-1:0] : aaddr_ff[MEM_AW-1:0]),
        .a_wdata (mem_wd),
        .a_rdata (amem_q),
        .b_clk   (burst_clk),
        .b_addr  (nxt_baddr[MEM_AW-1:0]),
        .b_rdata (bmem_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Output stage

    logic drive;
    logic wpol;
    logic async_ok;

    assign drive    = live && !c2_ff.oe_n && c2_ff.we_n;
    assign wpol     = read_config_reg[CFG_WAITPOL];
    assign async_ok = rd_req && acc_ff == 2'h0;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dq_out       <= 16'h0000;
            dq_oe        <= 1'b0;
            wait_out     <= 1'b0;
            wait_oe      <= 1'b0;
            program_busy <= 1'b0;
        end else begin
            program_busy <= pstate_ff == P_BUSY; // R5
            wait_oe      <= live; // R1 R4
            if (sync_mode) begin
                dq_oe    <= drive && bo2_ff.active; // R6 R10
                wait_out <= wpol ^ !(drive && bo2_ff.active && bo2_ff.wait_on); // R23
                if (tog_ff[2] != tog_ff[1]) begin
                    dq_out <= bo2_ff.word;
                end
            end else begin
                dq_oe    <= async_ok; // R6 R9
                wait_out <= wpol ^ !(rd_req && acc_ff != 2'h0); // R23
                dq_out   <= nonarray_mode ? nonarray_word : amem_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_write_end;
        wr_prev_ff && !wr_act && c2_ff.rst_n && pstate_ff == P_IDLE;
    endsequence

    sequence s_prog_start;
        pstate_ff == P_BUSY && pcnt_ff == 6'(PROG_CYC) && paddr_ff == $past(aaddr_ff);
    endsequence

    reset_hiz_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R1
        !c2_ff.rst_n |=> !dq_oe && !wait_oe)
        else $error("outputs driven while reset pin low");

    standby_hiz_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R4
        c2_ff.ce_n |=> !dq_oe && !wait_oe)
        else $error("outputs driven in standby");

    prog_abort_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R2
        pstate_ff == P_BUSY && !c2_ff.rst_n |-> mem_we ##2 !program_busy[*2])
        else $error("program not aborted by reset pin");

    prog_standby_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R5
        pstate_ff == P_BUSY && c2_ff.rst_n && pcnt_ff > 6'h01 |=> pstate_ff == P_BUSY)
        else $error("program stopped early");

    oe_off_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R6
        live && c2_ff.oe_n |=> !dq_oe && wait_oe && wait_out == wpol ^ 1'b1)
        else $error("output disable not honoured");

    async_delay_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R9
        $rose(rd_req) |=> !dq_oe[*3])
        else $error("async data before access delay");

    write_commit_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R20
        s_write_end |=> s_prog_start)
        else $error("write not taken on rising strobe");

    burst_start_a: assert property (@(posedge burst_clk) disable iff (!resetn) // R10
        bstate_ff == B_IDLE && bstart |=> bstate_ff == B_LAT ##1 bout_ff.wait_on)
        else $error("burst did not start with latency");

    burst_len_a: assert property (@(posedge burst_clk) disable iff (!resetn) // R12
        bemit && blast && !bdesel |=> bstate_ff == B_DONE)
        else $error("burst ran past its length");

    stall_bound_a: assert property (@(posedge burst_clk) disable iff (!resetn) // R19
        bstate_ff == B_STALL |-> bcnt_ff < lat_of(bcfg2_ff) && bstalled_ff)
        else $error("end of wordline stall too long");

    wrap_group_a: assert property (@(posedge burst_clk) disable iff (!resetn) // R17
        bemit && bcfg2_ff[CFG_WRAP_BIT] && len_of(bcfg2_ff) != 5'h00 && !bdesel
        |=> ((baddr_ff ^ $past(baddr_ff)) & ~(26'(len_of(bcfg2_ff)) - 26'h1)) == 26'h0)
        else $error("wrapped burst left its group");

endmodule

`default_nettype wire

// ===== rtl/flash_bus_pkg.sv
package flash_bus_pkg;

    // Bus control pins, all active low
    typedef struct packed {
        logic rst_n;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic addr_valid_n;
    } bus_ctrl_type;

    // Word handed from the burst domain to the output stage
    typedef struct packed {
        logic        active;
        logic        wait_on;
        logic [15:0] word;
    } burst_out_type;

    localparam int          REF_CLK_NS     = 40;
    localparam int          ACCESS_NS      = 106;
    localparam int          ACCESS_CYC     = (ACCESS_NS + REF_CLK_NS - 1) / REF_CLK_NS;
    localparam int          PROG_NS        = 2000;
    localparam int          PROG_CYC       = (PROG_NS + REF_CLK_NS - 1) / REF_CLK_NS;

    localparam int          MEM_AW         = 10;
    localparam int          WORDLINE_BITS  = 4;
    localparam int          SENSE_BITS     = 2;

    localparam int          CFG_SYNC_BIT   = 15;
    localparam int          CFG_LAT_LSB    = 11;
    localparam int          CFG_WAITPOL    = 10;
    localparam int          CFG_SPLIT_BIT  = 4;
    localparam int          CFG_WRAP_BIT   = 3;
    localparam int          CFG_BL_LSB     = 0;
    localparam logic [15:0] CFG_RESET      = 16'hBC07;

    localparam logic [2:0]  BL_8           = 3'h2;
    localparam logic [2:0]  BL_16          = 3'h3;
    localparam logic [2:0]  BL_CONT        = 3'h7;
    localparam logic [3:0]  LAT_MIN        = 4'h2;
    localparam logic [15:0] ABORT_MASK     = 16'h5A5A;

endpackage

// ===== rtl/flash_word_mem.sv
`timescale 1ns/1ps
`default_nettype none

module flash_word_mem (
    input  wire logic                          a_clk,
    input  wire logic                          a_we,
    input  wire logic [flash_bus_pkg::MEM_AW-1:0] a_addr,
    input  wire logic [15:0]                   a_wdata,
    output var  logic [15:0]                   a_rdata,
    input  wire logic                          b_clk,
    input  wire logic [flash_bus_pkg::MEM_AW-1:0] b_addr,
    output var  logic [15:0]                   b_rdata
);
    import flash_bus_pkg::*;

    logic [15:0] mem_ff [2**MEM_AW];

    // Program side with registered read
    always_ff @(posedge a_clk) begin
        if (a_we) begin
            mem_ff[a_addr] <= a_wdata;
        end
        a_rdata <= mem_ff[a_addr];
    end

    // Burst side read port
    always_ff @(posedge b_clk) begin
        b_rdata <= mem_ff[b_addr];
    end

endmodule

`default_nettype wire

// ===== tb/flash_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module flash_host_model (
    input  wire logic                        ref_clk,
    input  wire logic [15:0]                 dq_out,
    input  wire logic                        dq_oe,
    output var  logic                        burst_clk,
    output var  flash_bus_pkg::bus_ctrl_type ctrl,
    output var  logic [9:0]                  addr_hi,
    output wire logic [15:0]                 dq_in
);
    import flash_bus_pkg::*;

    logic [15:0] host_dq;
    logic        host_oe;

    // Released lines show the inverse of the last driven word
    assign dq_in = dq_oe ? dq_out : (host_oe ? host_dq : ~host_dq);

    initial begin
        burst_clk = 1'b0;
        ctrl      = 5'h1F;
        addr_hi   = 10'h000;
        host_dq   = 16'h0000;
        host_oe   = 1'b0;
    end

    task automatic drive(input bus_ctrl_type v);
        @(posedge ref_clk);
        #1 ctrl = v;
    endtask

    // Address on the shared lines while address valid is low
    task automatic addr_phase(input logic [15:0] a);
        @(posedge ref_clk);
        #1 ctrl = 5'h16;
        host_dq = a;
        host_oe = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1 ctrl.addr_valid_n = 1'b1;
    endtask

    task automatic bus_write(input logic [15:0] a, input logic [15:0] d);
        addr_phase(a);
        @(posedge ref_clk);
        #1 ctrl.we_n = 1'b0;
        host_dq = d;
        repeat (4) @(posedge ref_clk);
        #1 ctrl.we_n = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1 ctrl.ce_n = 1'b1;
        host_oe = 1'b0;
    endtask

    task automatic async_read(input logic [15:0] a, output logic [15:0] d, output logic ok);
        int n;
        addr_phase(a);
        @(posedge ref_clk);
        #1 ctrl.oe_n = 1'b0;
        host_oe = 1'b0;
        for (n = 0; n < 20 && dq_oe !== 1'b1; n++) begin
            @(posedge ref_clk);
            #1;
        end
        ok = dq_oe;
        d  = dq_out;
        @(posedge ref_clk);
        #1 ctrl.oe_n = 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask

    // Burst clock gives three idle cycles before the frame, then runs inside it
    task automatic burst(input logic [15:0] a, input int edges);
        // Idle clocks while deselected settle the burst side
        repeat (3) begin
            #80 burst_clk = 1'b1;
            #80 burst_clk = 1'b0;
        end
        @(posedge ref_clk);
        #1 ctrl = 5'h12;
        host_dq = a;
        host_oe = 1'b1;
        #17;
        for (int i = 0; i < edges; i++) begin
            #80 burst_clk = 1'b1;
            #40 if (i == 0) begin
                ctrl.addr_valid_n = 1'b1;
                host_oe = 1'b0;
            end
            #40 burst_clk = 1'b0;
        end
        repeat (6) @(posedge ref_clk);
        #1 ctrl = 5'h1F;
    endtask
endmodule

`default_nettype wire

// ===== tb/flash_muxed_bus_interface_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHECK(name, exp, got) \
    begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("CHECK FAILED %s expected %h seen %h", name, exp, got); end end

module flash_muxed_bus_interface_tb_top;
    import flash_bus_pkg::*;

    logic         ref_clk;
    logic         resetn;
    logic         burst_clk;
    bus_ctrl_type ctrl;
    logic [9:0]   addr_hi;
    wire  [15:0]  dq_in;
    logic [15:0]  dq_out;
    logic         dq_oe;
    logic         wait_out;
    logic         wait_oe;
    logic [15:0]  read_config_reg;
    logic         nonarray_mode;
    logic [15:0]  nonarray_word;
    logic         program_busy;
    logic         pol;
    logic         ok;
    logic [15:0]  rd;
    logic [15:0]  q[$];
    int           error_cnt;
    int           total_checks;
    int           cyc;

    flash_muxed_bus_interface #(.FAST_GRADE(1'b0)) i_flash_muxed_bus_interface (
        .ref_clk(ref_clk), .resetn(resetn), .burst_clk(burst_clk), .ctrl(ctrl),
        .addr_hi(addr_hi), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .wait_out(wait_out), .wait_oe(wait_oe), .read_config_reg(read_config_reg),
        .nonarray_mode(nonarray_mode), .nonarray_word(nonarray_word),
        .program_busy(program_busy));

    flash_host_model i_flash_host_model (
        .ref_clk(ref_clk), .dq_out(dq_out), .dq_oe(dq_oe), .burst_clk(burst_clk),
        .ctrl(ctrl), .addr_hi(addr_hi), .dq_in(dq_in));

    initial ref_clk = 1'b0;
    always #20 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    // Collect each new valid word seen at the pins
    always @(negedge ref_clk) begin
        if (dq_oe === 1'b1 && wait_out === ~pol && (q.size() == 0 || q[$] !== dq_out)) begin
            q.push_back(dq_out);
        end
    end

    function automatic logic [15:0] dat(input logic [15:0] a);
        return 16'hC000 | a;
    endfunction

    task automatic set_cfg(input logic sync, input logic p, input logic wrap);
        @(posedge ref_clk);
        #1 read_config_reg = {sync, 4'h3, p, 6'h00, wrap, 3'h1};
        pol = p;
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic t_reset();
        `CHECK("reset oe", 1'b0, dq_oe)
        `CHECK("reset wait", 1'b0, wait_oe)
        #1 resetn = 1'b1;
        repeat (8) @(posedge ref_clk);
    endtask

    task automatic t_write_read();
        logic [15:0] a;
        int n;
        for (int i = 0; i < 9; i++) begin
            a = (i < 5) ? 16'(i) : 16'(i + 9);
            i_flash_host_model.bus_write(a, dat(a));
            `CHECK("busy", 1'b1, program_busy)
            for (n = 0; n < 60 && program_busy !== 1'b0; n++) @(posedge ref_clk);
            `CHECK("done", 1'b0, program_busy)
        end
        for (int k = 0; k < 2; k++) begin
            a = k ? 16'h000F : 16'h0004;
            i_flash_host_model.async_read(a, rd, ok);
            `CHECK("async ok", 1'b1, ok)
            `CHECK("async word", dat(a), rd)
            `CHECK("oe off", 1'b0, dq_oe)
            `CHECK("wait off", ~pol, wait_out)
            i_flash_host_model.drive(5'h1F);
        end
    endtask

    task automatic t_standby_abort();
        i_flash_host_model.drive(5'h1B);
        repeat (6) @(posedge ref_clk);
        `CHECK("standby oe", 1'b0, dq_oe)
        i_flash_host_model.bus_write(16'h0006, 16'h1234);
        i_flash_host_model.drive(5'h03);
        repeat (6) @(posedge ref_clk);
        `CHECK("abort", 1'b0, program_busy)
        `CHECK("pin oe", 1'b0, dq_oe)
        `CHECK("pin wait", 1'b0, wait_oe)
        i_flash_host_model.drive(5'h1F);
        repeat (8) @(posedge ref_clk);
    endtask

    task automatic t_burst(input logic [15:0] s, input logic wrap, input logic p, input logic na);
        logic [15:0] a;
        set_cfg(1'b0, p, wrap);
        #1 nonarray_mode = na;
        q = {};
        i_flash_host_model.burst(s, 14);
        for (int k = 0; k < 4; k++) begin
            a = wrap ? {s[15:2], 2'(s[1:0] + k)} : 16'(s + k);
            if (na) begin
                `CHECK("same word", 32'(1), q.size())
                `CHECK("status word", nonarray_word, q[0])
            end else begin
                `CHECK("burst word", dat(a), q[k])
            end
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        resetn          = 1'b0;
        read_config_reg = {1'b1, 4'h3, 1'b1, 6'h00, 1'b0, 3'h1};
        pol             = 1'b1;
        nonarray_mode   = 1'b0;
        nonarray_word   = 16'h3C96;
        repeat (16) @(posedge ref_clk);
        t_reset();
        t_write_read();
        t_standby_abort();
        t_burst(16'h0001, 1'b1, 1'b1, 1'b0);
        t_burst(16'h0001, 1'b0, 1'b0, 1'b0);
        t_burst(16'h000E, 1'b0, 1'b1, 1'b0);
        t_burst(16'h0002, 1'b0, 1'b1, 1'b1);
        complete_run();
    end
endmodule

`default_nettype wire
